// ---- smrc_pkg.sv ----
// Purpose: shared constants for the sleep mode and reset control block
// Assumes: 10 MHz system clock
// Notes:   mode encodings follow the usual six-mode select field
package smrc_pkg;

  localparam int unsigned PORT_W        = 8;
  localparam int unsigned MODE_W        = 3;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // least reset pulse width, in ns
  localparam int unsigned RST_MIN_NS    = 2500;
  localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W     = 6;
  localparam logic [RST_CNT_W-1:0] RST_MIN_CNT = RST_CNT_W'(RST_MIN_CYC);

  typedef enum logic [MODE_W-1:0] {
    SMRC_MODE_IDLE     = 3'h0,
    SMRC_MODE_ADCNR    = 3'h1,
    SMRC_MODE_PWRDOWN  = 3'h2,
    SMRC_MODE_PWRSAVE  = 3'h3,
    SMRC_MODE_STANDBY  = 3'h6,
    SMRC_MODE_EXTSTBY  = 3'h7
  } smrc_mode_t;

  typedef enum logic [1:0] {
    SMRC_ST_RUN   = 2'h0,
    SMRC_ST_SLEEP = 2'h1,
    SMRC_ST_WAKE  = 2'h3
  } smrc_state_t;

  // gate vector bit positions
  localparam int unsigned G_CPU  = 0;
  localparam int unsigned G_OSC  = 1;
  localparam int unsigned G_ASY  = 2;
  localparam int unsigned G_ADC  = 3;
  localparam int unsigned G_IO   = 4;
  localparam int unsigned G_SPI  = 5;
  localparam int unsigned G_TMR  = 6;
  localparam int unsigned G_IRQ  = 7;
  localparam int unsigned G_W    = 8;
  localparam logic [G_W-1:0] G_ALL_ON = 8'hFF;

endpackage

// ---- smrc_port_gate.sv ----
// Purpose: one bidirectional port with reset-forced high impedance
// Assumes: rst_active is a combinational reset level
// Notes:   enable drops with no clock needed
`timescale 1ns/1ps
`default_nettype none
module smrc_port_gate
  import smrc_pkg::*;
(
  input  wire logic [PORT_W-1:0] pin_i,
  input  wire logic [PORT_W-1:0] out_val,
  input  wire logic [PORT_W-1:0] out_en,
  input  wire logic              rst_active,
  output logic      [PORT_W-1:0] pin_o,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] in_val
);
  assign pin_o  = rst_active ? '0 : out_val;
  assign pin_oe = rst_active ? '0 : out_en; // [RULE8]
  assign in_val = pin_i;
endmodule
`default_nettype wire

// ---- smrc_top.sv ----
// Purpose: sleep mode select, clock gating, wake-up and reset control
// Assumes: clk is the 10 MHz system clock; wake and sleep inputs synchronous
// Notes:   ports tri-state combinationally on any reset source
//
// Functional notes
// RULE1: six software selected sleep modes
// RULE2: idle halts CPU only
// RULE3: power-down stops oscillator until wake
// RULE4: power-save keeps asynchronous timer running
// RULE5: noise reduction keeps only timer, converter; code also keeps oscillator and interrupt clocks running
// RULE6: standby keeps main oscillator running
// RULE7: extended standby keeps oscillator and timer
// RULE8: all port pins tri-state during reset
// RULE9: long enough low reset pin resets device
// RULE10: sleep only on instruction, resume after wake
`timescale 1ns/1ps
`default_nettype none
module smrc_top
  import smrc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ext_reset_b,
  input  wire logic              other_reset,
  input  wire logic              sleep_enable,
  input  wire logic [MODE_W-1:0] sleep_mode_sel,
  input  wire logic              sleep_instr,
  input  wire logic              wake_irq,
  input  wire logic              wake_async_irq,
  input  wire logic [PORT_W-1:0] first_port_pins_i,
  input  wire logic [PORT_W-1:0] second_port_pins_i,
  input  wire logic [PORT_W-1:0] third_port_pins_i,
  input  wire logic [PORT_W-1:0] fourth_port_pins_i,
  input  wire logic [PORT_W-1:0] first_port_out,
  input  wire logic [PORT_W-1:0] second_port_out,
  input  wire logic [PORT_W-1:0] third_port_out,
  input  wire logic [PORT_W-1:0] fourth_port_out,
  input  wire logic [PORT_W-1:0] first_port_dir,
  input  wire logic [PORT_W-1:0] second_port_dir,
  input  wire logic [PORT_W-1:0] third_port_dir,
  input  wire logic [PORT_W-1:0] fourth_port_dir,
  output logic      [PORT_W-1:0] first_port_pins_o,
  output logic      [PORT_W-1:0] second_port_pins_o,
  output logic      [PORT_W-1:0] third_port_pins_o,
  output logic      [PORT_W-1:0] fourth_port_pins_o,
  output logic      [PORT_W-1:0] first_port_pins_oe,
  output logic      [PORT_W-1:0] second_port_pins_oe,
  output logic      [PORT_W-1:0] third_port_pins_oe,
  output logic      [PORT_W-1:0] fourth_port_pins_oe,
  output logic      [PORT_W-1:0] first_port_in,
  output logic      [PORT_W-1:0] second_port_in,
  output logic      [PORT_W-1:0] third_port_in,
  output logic      [PORT_W-1:0] fourth_port_in,
  output logic                   sys_reset_b,
  output logic                   cpu_clk_en,
  output logic                   osc_en,
  output logic                   async_timer_en,
  output logic                   adc_clk_en,
  output logic                   io_clk_en,
  output logic                   spi_clk_en,
  output logic                   timer_clk_en,
  output logic                   irq_clk_en,
  output logic                   sleeping,
  output logic                   wake_pulse
);

  // gating vector per mode; a bit set means that function stays clocked
  function automatic logic [G_W-1:0] mode_gates(input logic [MODE_W-1:0] m);
    logic [G_W-1:0] g;
    g = '0;
    case (m)
      SMRC_MODE_IDLE: begin
        g = G_ALL_ON;
        g[G_CPU] = 1'b0; // [RULE2]
      end
      SMRC_MODE_ADCNR: begin
        g[G_OSC] = 1'b1;
        g[G_ASY] = 1'b1;
        g[G_ADC] = 1'b1;
        g[G_IRQ] = 1'b1; // [RULE5]
      end
      SMRC_MODE_PWRDOWN: g = '0; // [RULE3]
      SMRC_MODE_PWRSAVE: g[G_ASY] = 1'b1; // [RULE4]
      SMRC_MODE_STANDBY: g[G_OSC] = 1'b1; // [RULE6]
      SMRC_MODE_EXTSTBY: begin
        g[G_OSC] = 1'b1;
        g[G_ASY] = 1'b1; // [RULE7]
      end
      default: g = G_ALL_ON;
    endcase
    return g;
  endfunction

  // only the six coded values are sleep modes
  function automatic logic mode_valid(input logic [MODE_W-1:0] m);
    logic v;
    v = 1'b0;
    case (m)
      SMRC_MODE_IDLE, SMRC_MODE_ADCNR, SMRC_MODE_PWRDOWN,
      SMRC_MODE_PWRSAVE, SMRC_MODE_STANDBY, SMRC_MODE_EXTSTBY: v = 1'b1; // [RULE1]
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // reset pin pulse filter
  logic [RST_CNT_W-1:0] rcnt_q, rcnt_d;
  logic                 pin_rst_q, pin_rst_d;

  always_comb begin
    rcnt_d    = rcnt_q;
    pin_rst_d = pin_rst_q;
    if (!ext_reset_b) begin
      if (rcnt_q < RST_MIN_CNT) begin
        rcnt_d = rcnt_q + RST_CNT_W'(1);
      end else begin
        pin_rst_d = 1'b1; // [RULE9]
      end
    end else begin
      rcnt_d    = '0;
      pin_rst_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_q    <= '0;
      pin_rst_q <= 1'b0;
    end else begin
      rcnt_q    <= rcnt_d;
      pin_rst_q <= pin_rst_d;
    end
  end

  logic rst_active;
  // clockless path: pin low forces ports off at once
  assign rst_active  = !rst_b || !ext_reset_b || other_reset; // [RULE8]
  assign sys_reset_b = rst_b && !pin_rst_q && !other_reset; // [RULE9]

  // sleep controller
  smrc_state_t          st_q, st_d;
  logic [MODE_W-1:0]    mode_q, mode_d;
  logic                 wake_q, wake_d;
  logic                 wake_ev;

  // power-down wakes only on an interrupt source that works without clocks
  always_comb begin
    case (mode_q)
      SMRC_MODE_IDLE, SMRC_MODE_ADCNR: wake_ev = wake_irq || wake_async_irq;
      SMRC_MODE_PWRSAVE, SMRC_MODE_EXTSTBY: wake_ev = wake_irq || wake_async_irq;
      default: wake_ev = wake_irq; // [RULE3]
    endcase
  end

  always_comb begin
    st_d   = st_q;
    mode_d = mode_q;
    wake_d = 1'b0;
    case (st_q)
      SMRC_ST_RUN: begin
        if (sleep_instr && sleep_enable && mode_valid(sleep_mode_sel)) begin
          st_d   = SMRC_ST_SLEEP; // [RULE10]
          mode_d = sleep_mode_sel;
        end
      end
      SMRC_ST_SLEEP: begin
        if (wake_ev) begin
          st_d   = SMRC_ST_WAKE;
          wake_d = 1'b1;
        end
      end
      SMRC_ST_WAKE: st_d = SMRC_ST_RUN; // [RULE10]
      default: st_d = SMRC_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= SMRC_ST_RUN;
      mode_q <= SMRC_MODE_IDLE;
      wake_q <= 1'b0;
    end else if (pin_rst_q || other_reset) begin
      st_q   <= SMRC_ST_RUN; // [RULE9]
      mode_q <= SMRC_MODE_IDLE;
      wake_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      mode_q <= mode_d;
      wake_q <= wake_d;
    end
  end

  logic [G_W-1:0] gates;
  assign gates = (st_q == SMRC_ST_SLEEP) ? mode_gates(mode_q) : G_ALL_ON;

  assign cpu_clk_en     = gates[G_CPU];
  assign osc_en         = gates[G_OSC];
  assign async_timer_en = gates[G_ASY];
  assign adc_clk_en     = gates[G_ADC];
  assign io_clk_en      = gates[G_IO];
  assign spi_clk_en     = gates[G_SPI];
  assign timer_clk_en   = gates[G_TMR];
  assign irq_clk_en     = gates[G_IRQ];
  assign sleeping       = (st_q == SMRC_ST_SLEEP);
  assign wake_pulse     = wake_q;

  smrc_port_gate u_port_a (
    .pin_i      (first_port_pins_i),
    .out_val    (first_port_out),
    .out_en     (first_port_dir),
    .rst_active (rst_active),
    .pin_o      (first_port_pins_o),
    .pin_oe     (first_port_pins_oe),
    .in_val     (first_port_in)
  );
  smrc_port_gate u_port_b (
    .pin_i      (second_port_pins_i),
    .out_val    (second_port_out),
    .out_en     (second_port_dir),
    .rst_active (rst_active),
    .pin_o      (second_port_pins_o),
    .pin_oe     (second_port_pins_oe),
    .in_val     (second_port_in)
  );
  smrc_port_gate u_port_c (
    .pin_i      (third_port_pins_i),
    .out_val    (third_port_out),
    .out_en     (third_port_dir),
    .rst_active (rst_active),
    .pin_o      (third_port_pins_o),
    .pin_oe     (third_port_pins_oe),
    .in_val     (third_port_in)
  );
  smrc_port_gate u_port_d (
    .pin_i      (fourth_port_pins_i),
    .out_val    (fourth_port_out),
    .out_en     (fourth_port_dir),
    .rst_active (rst_active),
    .pin_o      (fourth_port_pins_o),
    .pin_oe     (fourth_port_pins_oe),
    .in_val     (fourth_port_in)
  );

endmodule
`default_nettype wire

// ---- smrc_sva.sv ----
// Purpose: port checks for smrc_top
// Assumes: one clock domain
// Notes:   bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module smrc_sva (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ext_reset_b,
  input wire logic       other_reset,
  input wire logic       sleep_enable,
  input wire logic [2:0] sleep_mode_sel,
  input wire logic       sleep_instr,
  input wire logic       wake_irq,
  input wire logic [7:0] first_port_pins_oe,
  input wire logic [7:0] second_port_pins_oe,
  input wire logic [7:0] third_port_pins_oe,
  input wire logic [7:0] fourth_port_pins_oe,
  input wire logic       sys_reset_b,
  input wire logic       cpu_clk_en,
  input wire logic       osc_en,
  input wire logic       async_timer_en,
  input wire logic       io_clk_en,
  input wire logic       sleeping,
  input wire logic       wake_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic go;
  // accepted sleep request, no reset pending
  assign go = sleep_instr && sleep_enable && !other_reset && sys_reset_b
              && (sleep_mode_sel inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7});
  sleep_in_a: assert property (go && !sleeping && !wake_pulse |=> sleeping) else $error("no sleep");
  stay_awake_a: assert property (!sleeping && !go |=> !sleeping) else $error("bad sleep");
  wake_up_a: assert property (
    sleeping && wake_irq && !other_reset && sys_reset_b |=> wake_pulse && !sleeping) else $error("no wake");
  wake_once_a: assert property (wake_pulse |=> !wake_pulse && !sleeping) else $error("long wake");
  cpu_halt_a: assert property (sleeping |-> !cpu_clk_en) else $error("cpu runs");
  pdown_stop_a: assert property (
    $rose(sleeping) && $past(sleep_mode_sel) == 3'h2 |-> !osc_en && !async_timer_en && !io_clk_en)
    else $error("pdown gates");
  asy_keep_a: assert property (
    $rose(sleeping) && $past(sleep_mode_sel) inside {3'h1, 3'h3, 3'h7} |-> async_timer_en) else $error("asy off");
  osc_keep_a: assert property (
    $rose(sleeping) && $past(sleep_mode_sel) inside {3'h6, 3'h7} |-> osc_en) else $error("osc off");
  tri_state_a: assert property (
    !ext_reset_b || other_reset |-> !(|{first_port_pins_oe, second_port_pins_oe, third_port_pins_oe,
    fourth_port_pins_oe})) else $error("pins driven");
  pin_filter_a: assert property (
    $fell(sys_reset_b) && !other_reset |-> !$past(ext_reset_b, 20)) else $error("short reset");
  cover property ($rose(sleeping));
  cover property (wake_pulse);
  cover property ($fell(sys_reset_b));
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for smrc_top
// Assumes: inputs change on falling edge
// Notes:   one vector feeds all four ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 0, rst_b = 0, ext_reset_b = 1, other_reset = 0;
  logic       sleep_enable = 0, sleep_instr = 0, wake_irq = 0, wake_async_irq = 0;
  logic [2:0] sleep_mode_sel = 0;
  logic [7:0] pv = 8'hA5, pd = 8'hFF, pi = 8'h3C;
  wire  [7:0] g, po [4], oe [4], pin [4];
  wire        sys_reset_b, sleeping, wake_pulse;
  int         mismatches = 0, n_tests = 0;

  smrc_top dut (.clk, .rst_b, .ext_reset_b, .other_reset, .sleep_enable, .sleep_mode_sel, .sleep_instr,
    .wake_irq, .wake_async_irq, .first_port_pins_i(pi), .second_port_pins_i(pi), .third_port_pins_i(pi),
    .fourth_port_pins_i(pi), .first_port_out(pv), .second_port_out(pv), .third_port_out(pv),
    .fourth_port_out(pv), .first_port_dir(pd), .second_port_dir(pd), .third_port_dir(pd), .fourth_port_dir(pd),
    .first_port_pins_o(po[0]), .second_port_pins_o(po[1]), .third_port_pins_o(po[2]), .fourth_port_pins_o(po[3]),
    .first_port_pins_oe(oe[0]), .second_port_pins_oe(oe[1]), .third_port_pins_oe(oe[2]),
    .fourth_port_pins_oe(oe[3]), .first_port_in(pin[0]), .second_port_in(pin[1]), .third_port_in(pin[2]),
    .fourth_port_in(pin[3]), .sys_reset_b, .cpu_clk_en(g[0]), .osc_en(g[1]), .async_timer_en(g[2]),
    .adc_clk_en(g[3]), .io_clk_en(g[4]), .spi_clk_en(g[5]), .timer_clk_en(g[6]), .irq_clk_en(g[7]),
    .sleeping, .wake_pulse);

  always #50 clk = ~clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk({oe[0], oe[1], oe[2], oe[3], po[0], sys_reset_b, sleeping}, 0);
    repeat (3) @(negedge clk);
    rst_b = 1;
    @(negedge clk);
    chk({oe[0], oe[3], po[1], pin[2], g}, 40'hFFFFA53CFF);
    chk({po[0], po[2], po[3], pin[0], pin[1], pin[3], oe[1], oe[2]}, 64'hA5A5A53C3C3CFFFF);
  endtask

  task automatic t_modes();
    logic [2:0] m  [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [7:0] ex [6] = '{8'hE0, 8'h0E, 8'h00, 8'h04, 8'h02, 8'h06};
    logic [7:0] mk [6] = '{8'hE1, 8'h7F, 8'hFF, 8'h15, 8'h1F, 8'h17};
    sleep_enable = 1;
    for (int i = 0; i < 6; i++) begin
      sleep_mode_sel = m[i];
      sleep_instr = 1;
      @(negedge clk);
      sleep_instr = 0;
      chk({sleeping, g & mk[i]}, {1'b1, ex[i]});
      // async wake ends every mode but power-down and standby
      wake_async_irq = 1;
      @(negedge clk);
      wake_async_irq = 0;
      if (m[i] inside {3'h2, 3'h6}) begin
        chk(sleeping, 1);
        wake_irq = 1;
        @(negedge clk);
        wake_irq = 0;
      end
      chk({wake_pulse, sleeping, g}, 10'h2FF);
      @(negedge clk);
      chk(wake_pulse, 0);
    end
  endtask

  task automatic t_refuse();
    sleep_instr = 1;
    sleep_mode_sel = 3'h4;
    @(negedge clk);
    sleep_enable = 0;
    sleep_mode_sel = 3'h2;
    @(negedge clk);
    sleep_instr = 0;
    sleep_enable = 1;
    chk(sleeping, 0);
    @(negedge clk);
    chk(sleeping, 0);
  endtask

  task automatic t_other();
    sleep_instr = 1;
    @(negedge clk);
    sleep_instr = 0;
    other_reset = 1;
    #1;
    chk({po[2], oe[0], oe[1], oe[2], oe[3], sys_reset_b}, 0);
    @(negedge clk);
    other_reset = 0;
    chk(sleeping, 0);
  endtask

  task automatic t_pin();
    sleep_instr = 1;
    @(negedge clk);
    sleep_instr = 0;
    chk(sleeping, 1);
    ext_reset_b = 0;
    #1;
    chk({oe[0], oe[1], oe[2], oe[3], sys_reset_b}, 33'h1);
    repeat (smrc_pkg::RST_MIN_CYC) @(negedge clk);
    chk(sys_reset_b, 1);
    @(negedge clk);
    chk(sys_reset_b, 0);
    ext_reset_b = 1;
    repeat (2) @(negedge clk);
    chk({sys_reset_b, sleeping}, 2'h2);
  endtask

  initial begin
    #1;
    t_reset();
    t_modes();
    t_refuse();
    t_other();
    t_pin();
    wrap_up();
  end

  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule

bind smrc_top smrc_sva sva_i (.*);
`default_nettype wire
